//--- rtl/ebs_pkg.sv
package ebs_pkg;
   // Bus widths
   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;
   localparam int CS_W = 4;
   // Bus width select codes
   localparam logic BUS_8 = 1'b0;
   localparam logic BUS_16 = 1'b1;
   // Strobe scheme select codes
   localparam logic SCHEME_SPLIT = 1'b0;
   localparam logic SCHEME_SINGLE = 1'b1;
   // Phase lengths in system clock cycles
   localparam int ALE_CYCLES = 1;
   localparam int STROBE_CYCLES = 2;
   localparam logic [1:0] PH_CNT_ZERO = 2'h0;
   // Byte lane, idle select and zero address constants
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [15:0] WORD_ZERO = 16'h0000;
   localparam logic [3:0] CS_IDLE = 4'hF;
   localparam logic [19:0] ADDR_ZERO = 20'h0_0000;

   // One-hot bus states
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_ADDR = 5'b00010,
      ST_STRB = 5'b00100,
      ST_DONE = 5'b01000,
      ST_HOLD = 5'b10000
   } ebs_state_t;
endpackage

//--- rtl/ebs_strobe_ctrl.sv
`timescale 1ns/100ps
// What this block does
// - Software picks split or single write strobes
// - Split scheme: even byte writes low strobe
// - Split scheme: odd byte writes high strobe
// - Read strobe low during reads; bus sampled
// - Single strobe write; upper enable on odd
// - Hold state while bus request low
// - Grant output low exactly during hold
// - Address latch pulse output each cycle
// - Ready low stretches current bus cycle
// - Muxed bus shares address and data on either width
// - Four space selects mark target space
// - Separate bus uses dedicated address/data
module ebs_strobe_ctrl
   import ebs_pkg::*;
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_resetn,
   // Configuration
   input wire logic i_scheme_single,
   input wire logic i_bus_16,
   input wire logic i_muxed,
   // Internal request side
   input wire logic i_req,
   input wire logic i_req_write,
   input wire logic i_req_word,
   input wire logic [ebs_pkg::ADDR_W-1:0] i_req_addr,
   input wire logic [ebs_pkg::DATA_W-1:0] i_req_wdata,
   input wire logic [ebs_pkg::CS_W-1:0] i_req_space,
   output logic o_req_done,
   output logic [ebs_pkg::DATA_W-1:0] o_req_rdata,
   output logic o_busy,
   // External control
   input wire logic i_bus_request_n,
   input wire logic i_ready_n,
   output logic o_bus_grant_out_n,
   output logic o_addr_latch,
   output logic o_read_n,
   output logic o_low_byte_store_n,
   output logic o_high_byte_store_n,
   output logic o_ctrl_oe,
   output logic [ebs_pkg::CS_W-1:0] o_space_selects_n,
   // Address and data pins
   output logic [ebs_pkg::ADDR_W-1:0] o_addr,
   output logic o_addr_oe,
   input wire logic [ebs_pkg::DATA_W-1:0] i_data,
   output logic [ebs_pkg::DATA_W-1:0] o_data,
   output logic o_data_oe,
   // Bus clock
   output logic o_bus_clock
);
   import ebs_pkg::*;

   // ************************
   // Reset release
   // ************************
   logic rstn;

   ebs_sync u_sync (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .o_resetn(rstn)
   );

   // ************************
   // Helpers
   // ************************
   // Which write strobes fall for an access; shared by captured and incoming requests
   function automatic logic [1:0] lane_sel(input logic word, input logic a0);
      lane_sel = word ? 2'b11 : (a0 ? 2'b10 : 2'b01);
   endfunction

   // ************************
   // Cycle state
   // ************************
   ebs_state_t state_r;
   ebs_state_t state_nxt;
   logic [1:0] cnt_r;
   logic wr_r;
   logic word_r;
   logic [ADDR_W-1:0] addr_r;
   logic [DATA_W-1:0] wdata_r;
   logic [CS_W-1:0] space_r;
   logic [1:0] lanes;
   logic word_in;
   logic [1:0] lanes_in;

   assign lanes = lane_sel(word_r, addr_r[0]);
   assign word_in = i_req_word && (i_bus_16 == BUS_16) && !i_req_addr[0];
   assign lanes_in = lane_sel(word_in, i_req_addr[0]);

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (!i_bus_request_n) begin
               state_nxt = ST_HOLD;
            end else if (i_req) begin
               state_nxt = ST_ADDR;
            end
         end
         ST_ADDR: begin
            state_nxt = ST_STRB;
         end
         ST_STRB: begin
            if (cnt_r == PH_CNT_ZERO && i_ready_n) begin
               state_nxt = ST_DONE;
            end
         end
         ST_DONE: begin
            state_nxt = ST_IDLE;
         end
         ST_HOLD: begin
            if (i_bus_request_n) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge rstn) begin
      if (!rstn) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Strobe width counter; ready stretches the last beat
   always_ff @(posedge i_clock or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= PH_CNT_ZERO;
      end else if (state_r == ST_ADDR) begin
         cnt_r <= 2'(STROBE_CYCLES - 1);
      end else if (state_r == ST_STRB && cnt_r != PH_CNT_ZERO) begin
         cnt_r <= cnt_r - 2'd1;
      end
   end

   // Request capture; byte mode forces single-byte accesses
   always_ff @(posedge i_clock or negedge rstn) begin
      if (!rstn) begin
         wr_r <= 1'b0;
         word_r <= 1'b0;
         addr_r <= ADDR_ZERO;
         wdata_r <= WORD_ZERO;
         space_r <= CS_IDLE;
      end else if (state_r == ST_IDLE && state_nxt == ST_ADDR) begin
         wr_r <= i_req_write;
         word_r <= word_in;
         addr_r <= i_req_addr;
         wdata_r <= i_req_wdata;
         space_r <= ~i_req_space;
      end
   end

   // ************************
   // Pin outputs, all registered
   // ************************
   always_ff @(posedge i_clock or negedge rstn) begin
      if (!rstn) begin
         o_bus_grant_out_n <= 1'b1;
         o_ctrl_oe <= 1'b1;
         o_addr_oe <= 1'b1;
      end else begin
         o_bus_grant_out_n <= (state_nxt != ST_HOLD);
         o_ctrl_oe <= (state_nxt != ST_HOLD);
         o_addr_oe <= (state_nxt != ST_HOLD);
      end
   end

   always_ff @(posedge i_clock or negedge rstn) begin
      if (!rstn) begin
         o_addr_latch <= 1'b0;
         o_read_n <= 1'b1;
         o_low_byte_store_n <= 1'b1;
         o_high_byte_store_n <= 1'b1;
         o_space_selects_n <= CS_IDLE;
      end else begin
         o_addr_latch <= (state_nxt == ST_ADDR);
         o_read_n <= !(state_nxt == ST_STRB && !wr_r);
         if (state_nxt == ST_ADDR || state_nxt == ST_STRB) begin
            o_space_selects_n <= (state_r == ST_IDLE) ? ~i_req_space : space_r;
         end else begin
            o_space_selects_n <= CS_IDLE;
         end
         if (i_scheme_single == SCHEME_SPLIT) begin
            o_low_byte_store_n <= !(state_nxt == ST_STRB && wr_r && lanes[0]);
            o_high_byte_store_n <= !(state_nxt == ST_STRB && wr_r && lanes[1]);
         end else begin
            o_low_byte_store_n <= !(state_nxt == ST_STRB && wr_r);
            if (state_nxt == ST_ADDR || state_nxt == ST_STRB) begin
               o_high_byte_store_n <= (state_r == ST_IDLE) ? !lanes_in[1] : !lanes[1];
            end else begin
               o_high_byte_store_n <= 1'b1;
            end
         end
      end
   end

   // Address drive: muxed bus carries address only in the address phase
   always_ff @(posedge i_clock or negedge rstn) begin
      if (!rstn) begin
         o_addr <= ADDR_ZERO;
         o_data <= WORD_ZERO;
         o_data_oe <= 1'b0;
      end else if (state_nxt == ST_ADDR) begin
         o_addr <= i_req_addr;
         o_data <= i_muxed ? i_req_addr[DATA_W-1:0] : WORD_ZERO;
         o_data_oe <= i_muxed;
      end else if (state_nxt == ST_STRB && wr_r) begin
         if (i_bus_16 == BUS_8 && addr_r[0]) begin
            o_data <= {wdata_r[7:0], wdata_r[7:0]};
         end else begin
            o_data <= wdata_r;
         end
         o_data_oe <= 1'b1;
      end else begin
         o_data_oe <= 1'b0;
      end
   end

   // Read capture and completion; 8-bit bus reads the low lane
   always_ff @(posedge i_clock or negedge rstn) begin
      if (!rstn) begin
         o_req_done <= 1'b0;
         o_req_rdata <= WORD_ZERO;
         o_busy <= 1'b0;
      end else begin
         o_req_done <= (state_nxt == ST_DONE);
         o_busy <= (state_nxt != ST_IDLE);
         if (state_r == ST_STRB && state_nxt == ST_DONE && !wr_r) begin
            if (i_bus_16 == BUS_8 || !word_r) begin
               o_req_rdata <= {BYTE_ZERO,
                  (i_bus_16 == BUS_16 && addr_r[0]) ? i_data[15:8] : i_data[7:0]};
            end else begin
               o_req_rdata <= i_data;
            end
         end
      end
   end

   // Bus clock: half system rate, free running
   always_ff @(posedge i_clock or negedge rstn) begin
      if (!rstn) begin
         o_bus_clock <= 1'b0;
      end else begin
         o_bus_clock <= ~o_bus_clock;
      end
   end

   // ************************
   // Checks
   // ************************
   sequence s_latch;
      o_addr_latch ##1 !o_addr_latch;
   endsequence

   a_grant_in_hold: assert property (@(posedge i_clock) disable iff (!rstn)
      (state_r == ST_HOLD) |-> !o_bus_grant_out_n) else $error("grant high in hold");
   a_grant_idle: assert property (@(posedge i_clock) disable iff (!rstn)
      (state_r != ST_HOLD) |-> o_bus_grant_out_n) else $error("grant low outside hold");
   a_hold_entry: assert property (@(posedge i_clock) disable iff (!rstn)
      (state_r == ST_IDLE && !i_bus_request_n) |=> !o_bus_grant_out_n)
      else $error("hold not entered");
   a_hold_release: assert property (@(posedge i_clock) disable iff (!rstn)
      !o_bus_grant_out_n |-> !o_ctrl_oe && !o_addr_oe && !o_data_oe)
      else $error("pins driven in hold");
   a_latch_first: assert property (@(posedge i_clock) disable iff (!rstn)
      s_latch |-> !o_read_n || !o_low_byte_store_n || !o_high_byte_store_n)
      else $error("no strobe after latch");
   a_latch_no_strobe: assert property (@(posedge i_clock) disable iff (!rstn)
      o_addr_latch |-> o_read_n && o_low_byte_store_n
      && (i_scheme_single == SCHEME_SINGLE || o_high_byte_store_n)) else $error("strobe with latch");
   a_read_after: assert property (@(posedge i_clock) disable iff (!rstn)
      (o_addr_latch && !wr_r) |=> !o_read_n) else $error("read strobe late");
   a_split_even: assert property (@(posedge i_clock) disable iff (!rstn)
      (i_scheme_single == SCHEME_SPLIT && !o_low_byte_store_n && !word_r) |-> !addr_r[0])
      else $error("low strobe on odd");
   a_split_odd: assert property (@(posedge i_clock) disable iff (!rstn)
      (i_scheme_single == SCHEME_SPLIT && !o_high_byte_store_n && !word_r) |-> addr_r[0])
      else $error("high strobe on even");
   a_ready_wait: assert property (@(posedge i_clock) disable iff (!rstn)
      (state_r == ST_STRB && i_ready_n == 1'b0) |=> state_r == ST_STRB)
      else $error("wait not honoured");
   a_done_pulse: assert property (@(posedge i_clock) disable iff (!rstn)
      o_req_done |=> !o_req_done) else $error("done stuck");
endmodule

//--- rtl/ebs_sync.sv
`timescale 1ns/100ps
// Two-stage reset release; first stage feeds only the second
module ebs_sync (
   input wire logic i_clock,
   input wire logic i_resetn,
   output logic o_resetn
);
   logic stage_r;

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         stage_r <= 1'b0;
         o_resetn <= 1'b0;
      end else begin
         stage_r <= 1'b1;
         o_resetn <= stage_r;
      end
   end
endmodule

//--- verification/ebs_mem_model.sv
`timescale 1ns/100ps
// ***************************************
// External byte memory with wait control
// ***************************************
module ebs_mem_model
   import ebs_pkg::*;
(
   // Clock
   input wire logic i_clock,
   // Bus from the block
   input wire logic i_addr_latch,
   input wire logic [ebs_pkg::ADDR_W-1:0] i_addr,
   input wire logic [ebs_pkg::DATA_W-1:0] i_wdata,
   input wire logic i_read_n,
   input wire logic i_lo_n,
   input wire logic i_hi_n,
   // Setup and wait request
   input wire logic i_single,
   input wire logic i_bus_16,
   input wire logic [1:0] i_waits,
   // Answer
   output logic [ebs_pkg::DATA_W-1:0] o_rdata,
   output logic o_ready_n
);
   logic [7:0] mem_r [16];
   logic [3:0] a_r;
   logic [1:0] wcnt_r = 2'h0;
   logic [15:0] last_r = 16'h0000;
   logic [15:0] rd_word;
   logic act;
   // Upper enable is not a strobe in the single scheme
   assign act = !i_read_n || !i_lo_n || (!i_single && !i_hi_n);
   assign rd_word = i_bus_16 ? {mem_r[a_r | 4'h1], mem_r[a_r & 4'hE]} : {mem_r[a_r], mem_r[a_r]};
   assign o_ready_n = !(act && wcnt_r < i_waits);
   // Released lines show the inverse so a stale value never passes
   assign o_rdata = !i_read_n ? rd_word : ~last_r;
   always_ff @(posedge i_clock) begin
      if (i_addr_latch) a_r <= i_addr[3:0];
      wcnt_r <= act ? wcnt_r + {1'b0, !o_ready_n} : 2'h0;
      if (!i_read_n) last_r <= rd_word;
      if (i_single && !i_lo_n) mem_r[a_r] <= i_wdata[7:0];
      if (!i_single && !i_lo_n) mem_r[a_r & 4'hE] <= i_wdata[7:0];
      if (!i_single && !i_hi_n) mem_r[a_r | 4'h1] <= i_wdata[15:8];
   end
endmodule

//--- verification/tb_external_bus_strobe_control.sv
`timescale 1ns/100ps
module tb_external_bus_strobe_control;
   import ebs_pkg::*;
   logic clk = 0, rstn = 0, single = 0, b16 = 1, req = 0, wr = 0, word = 0, muxed = 0;
   logic busreq_n = 1, grant_n, latch, rd_n, lo_n, hi_n, coe, aoe, doe, bclk, done, busy;
   logic ready_n, seen_lo, seen_hi, seen_rd, late_latch, cs_bad, addr_bad;
   logic [1:0] waits = 2'h0;
   logic [3:0] space = 4'h1, cs_n;
   logic [19:0] addr = 20'h0_0000, a_o;
   logic [15:0] wd = 16'h0000, d_o, d_i, rdata;
   int failures = 0, checks_done = 0, n;
   initial forever #2.5 clk = ~clk;
   ebs_strobe_ctrl dut_u (.i_clock(clk), .i_resetn(rstn), .i_scheme_single(single),
      .i_bus_16(b16), .i_muxed(muxed), .i_req(req), .i_req_write(wr), .i_req_word(word),
      .i_req_addr(addr), .i_req_wdata(wd), .i_req_space(space), .o_req_done(done),
      .o_req_rdata(rdata), .o_busy(busy), .i_bus_request_n(busreq_n), .i_ready_n(ready_n),
      .o_bus_grant_out_n(grant_n), .o_addr_latch(latch), .o_read_n(rd_n),
      .o_low_byte_store_n(lo_n), .o_high_byte_store_n(hi_n), .o_ctrl_oe(coe),
      .o_space_selects_n(cs_n), .o_addr(a_o), .o_addr_oe(aoe), .i_data(d_i), .o_data(d_o),
      .o_data_oe(doe), .o_bus_clock(bclk));
   ebs_mem_model mem_u (.i_clock(clk), .i_addr_latch(latch), .i_addr(a_o), .i_wdata(d_o),
      .i_read_n(rd_n), .i_lo_n(lo_n), .i_hi_n(hi_n), .i_single(single), .i_bus_16(b16),
      .i_waits(waits), .o_rdata(d_i), .o_ready_n(ready_n));
   // ***************************************
   // Checking and closing
   // ***************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks=%0d failures=%0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // One access; strobe activity is gathered mid-cycle
   task automatic access(input logic w, input logic wo, input logic [19:0] a,
                         input logic [15:0] d);
      @(posedge clk);
      req <= 1;
      wr <= w;
      word <= wo;
      addr <= a;
      wd <= d;
      @(posedge clk);
      req <= 0;
      {seen_lo, seen_hi, seen_rd, late_latch, cs_bad, addr_bad} = 6'h00;
      for (n = 1; n < 20; n++) begin
         @(negedge clk);
         if (latch && (seen_lo || seen_rd)) late_latch = 1;
         if (latch && cs_n !== ~space) cs_bad = 1;
         if (latch && a_o !== addr) addr_bad = 1;
         if (latch && muxed && (!doe || d_o[7:0] !== addr[7:0])) addr_bad = 1;
         seen_lo |= !lo_n;
         seen_hi |= !hi_n;
         seen_rd |= !rd_n;
         if (done === 1'b1) break;
      end
   endtask
   // ***************************************
   // Scenarios
   // ***************************************
   task automatic t_split();
      single <= 0;
      b16 <= 1;
      space <= 4'h2;
      access(1, 0, 20'h0_0004, 16'h00A5);
      chk({seen_lo, seen_hi, seen_rd}, 3'b100);
      chk({late_latch, cs_bad}, 2'b00);
      chk(n, 4);
      chk(addr_bad, 0);
      access(1, 0, 20'h0_0005, 16'h5A5A);
      chk({seen_lo, seen_hi, seen_rd}, 3'b010);
      access(0, 1, 20'h0_0004, 16'h0000);
      chk({seen_lo, seen_hi, seen_rd}, 3'b001);
      chk(rdata, 16'h5AA5);
      access(1, 1, 20'h0_0006, 16'h1234);
      chk({seen_lo, seen_hi}, 2'b11);
   endtask
   task automatic t_single();
      @(posedge clk);
      single <= 1;
      b16 <= 0;
      muxed <= 1;
      space <= 4'h8;
      access(1, 0, 20'h0_0009, 16'h3C3C);
      chk({seen_lo, seen_hi, cs_bad}, 3'b110);
      access(1, 0, 20'h0_0008, 16'h7171);
      chk({seen_lo, seen_hi}, 2'b10);
      access(0, 0, 20'h0_0009, 16'h0000);
      chk({seen_rd, rdata[7:0]}, {1'b1, 8'h3C});
      chk(addr_bad, 0);
   endtask
   task automatic t_wait();
      @(posedge clk);
      waits <= 2'h2;
      space <= 4'h4;
      muxed <= 0;
      access(0, 0, 20'h0_0008, 16'h0000);
      chk(n, 5);
      chk(rdata[7:0], 8'h71);
      chk(cs_bad, 0);
      waits <= 2'h0;
   endtask
   task automatic t_hold();
      logic bclk_was;
      @(posedge clk);
      busreq_n <= 0;
      repeat (3) @(posedge clk);
      req <= 1;
      repeat (4) @(negedge clk);
      chk({grant_n, coe, aoe, doe, done}, 5'h00);
      bclk_was = bclk;
      @(negedge clk);
      chk({busy, bclk}, {1'b1, ~bclk_was});
      @(posedge clk);
      req <= 0;
      busreq_n <= 1;
      repeat (3) @(negedge clk);
      chk({grant_n, coe, aoe}, 3'b111);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rstn <= 1;
      repeat (3) @(posedge clk);
      t_split();
      t_single();
      t_wait();
      t_hold();
      print_verdict();
   end
   initial begin
      #20000;
      failures++;
      print_verdict();
   end
endmodule
